//--- core/kwe_map.svh
// register map and field constants for the keyboard wake event block
// assumes a classic wishbone slave with word-aligned byte addresses
`ifndef KWE_MAP_SVH
`define KWE_MAP_SVH

// ====================================================================
// register byte offsets
`define KWE_OFF_WAKE_CTRL      8'h04
`define KWE_OFF_PROTO_CTRL     8'h08
`define KWE_OFF_SHIFTER        8'h0C
`define KWE_OFF_STATUS         8'h10
`define KWE_OFF_KEY_BASE       8'h20
`define KWE_OFF_KEY_LAST       8'h3C

// ====================================================================
// reset values
`define KWE_RST_WAKE_CTRL      8'h40
`define KWE_RST_PROTO_CTRL     8'h10
`define KWE_RST_KEY            8'h00

// ====================================================================
// wake control field positions
`define KWE_MODE_HI            7
`define KWE_MODE_LO            6
`define KWE_EV3_HI             5
`define KWE_EV3_LO             4
`define KWE_EV2_HI             3
`define KWE_EV2_LO             2
`define KWE_EV1_HI             1
`define KWE_EV1_LO             0

// first stored byte of each event sequence
`define KWE_EV1_BASE           3'h0
`define KWE_EV2_BASE           3'h3
`define KWE_EV3_BASE           3'h6

`endif

//--- core/kwe_pkg.sv
// types shared by the keyboard wake event block
// assumes kwe_map.svh provides the numeric constants
package kwe_pkg;

    // ================================================================
    // keyboard wake modes
    typedef enum logic [1:0] {
        KWE_MODE_SEQ  = 2'h0,
        KWE_MODE_ANY  = 2'h1,
        KWE_MODE_PM   = 2'h2,
        KWE_MODE_RSVD = 2'h3
    } kwe_mode_t;

    // ================================================================
    // byte-in-flight tracking of the shifter
    typedef enum logic [1:0] {
        KWE_RX_IDLE = 2'b01,
        KWE_RX_DONE = 2'b10
    } kwe_rx_state_t;

endpackage : kwe_pkg

//--- core/kwe_shifter.sv
// keyboard byte shifter: synchronises a byte strobe and captures the byte
// assumes the receiver outside presents a byte and a level-toggle strobe
`timescale 1ns/1ps
module kwe_shifter
    import kwe_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] kbd_byte_i,
    input  wire logic       kbd_toggle_i,
    output logic [7:0]      shifter_o,
    output logic            byte_valid_o
);

    // ================================================================
    // two-stage sync of the toggle and data lines
    logic       tog_s1_reg,  tog_s2_reg,  tog_s3_reg;
    logic [7:0] dat_s1_reg,  dat_s2_reg;
    logic [7:0] shift_reg,   shift_next;
    logic       valid_reg,   valid_next;
    kwe_rx_state_t st_reg, st_next;

    // next-state: a byte lands only while detection is enabled [R10]
    always_comb
    begin
        shift_next = shift_reg;
        valid_next = 1'b0;
        st_next    = KWE_RX_IDLE;
        case (st_reg)
            KWE_RX_IDLE, KWE_RX_DONE:
            begin
                if (enable_i && (tog_s3_reg != tog_s2_reg))
                begin
                    shift_next = dat_s2_reg;   // [R10]
                    valid_next = 1'b1;
                    st_next    = KWE_RX_DONE;
                end
            end
            default: st_next = KWE_RX_IDLE;
        endcase
    end

    // registers; data sync stages sit beside the toggle so both settle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            dat_s1_reg <= 8'h00;
            dat_s2_reg <= 8'h00;
            shift_reg  <= 8'h00;
            valid_reg  <= 1'b0;
            st_reg     <= KWE_RX_IDLE;
        end
        else
        begin
            tog_s1_reg <= kbd_toggle_i;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            dat_s1_reg <= kbd_byte_i;
            dat_s2_reg <= dat_s1_reg;
            shift_reg  <= shift_next;
            valid_reg  <= valid_next;
            st_reg     <= st_next;
        end
    end

    assign shifter_o    = shift_reg;
    assign byte_valid_o = valid_reg;

    // ================================================================
    // checks
    property p_shift_capture;
        @(posedge clk_i) disable iff (rst_i)
        (enable_i && tog_s3_reg != tog_s2_reg) |=> (valid_reg && shift_reg == $past(dat_s2_reg));
    endproperty
    a_shift_capture: assert property (p_shift_capture) else $error("byte not captured"); // [R10]

    property p_shift_hold;
        @(posedge clk_i) disable iff (rst_i)
        !enable_i |=> (shift_reg == $past(shift_reg)) && !valid_reg;
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shifter moved while disabled"); // [R10]

endmodule : kwe_shifter

//--- core/kwe_seq_match.sv
// one sequence matcher: compares up to three received bytes in order
// assumes bytes arrive as one-cycle valid pulses on the block clock
`timescale 1ns/1ps
module kwe_seq_match
    import kwe_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       arm_i,
    input  wire logic [1:0] len_i,
    input  wire logic [7:0] key0_i,
    input  wire logic [7:0] key1_i,
    input  wire logic [7:0] key2_i,
    input  wire logic       byte_valid_i,
    input  wire logic [7:0] byte_i,
    output logic            hit_o
);

    // ================================================================
    logic [1:0] pos_reg, pos_next;
    logic       hit_reg, hit_next;
    logic [7:0] expect_b;

    // stored byte expected at the current position
    always_comb
    begin
        case (pos_reg)
            2'h0:    expect_b = key0_i;
            2'h1:    expect_b = key1_i;
            default: expect_b = key2_i;
        endcase
    end

    // advance on a match, restart on a miss; disarmed holds at start
    always_comb
    begin
        pos_next = pos_reg;
        hit_next = 1'b0;
        if (!arm_i || len_i == 2'h0)
            pos_next = 2'h0;
        else if (byte_valid_i)
        begin
            if (byte_i == expect_b)
            begin
                if (pos_reg + 2'h1 == len_i)
                begin
                    hit_next = 1'b1;   // [R9]
                    pos_next = 2'h0;
                end
                else
                    pos_next = pos_reg + 2'h1;
            end
            // a miss may itself be the first byte of a fresh attempt
            else if (byte_i == key0_i)
            begin
                if (len_i == 2'h1)
                begin
                    hit_next = 1'b1;
                    pos_next = 2'h0;
                end
                else
                    pos_next = 2'h1;   // [R11]
            end
            else
                pos_next = 2'h0;   // [R11]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pos_reg <= 2'h0;
            hit_reg <= 1'b0;
        end
        else
        begin
            pos_reg <= pos_next;
            hit_reg <= hit_next;
        end
    end

    assign hit_o = hit_reg;

    // ================================================================
    property p_miss_restart;
        @(posedge clk_i) disable iff (rst_i)
        (arm_i && byte_valid_i && byte_i != expect_b && byte_i != key0_i) |=> pos_reg == 2'h0;
    endproperty
    a_miss_restart: assert property (p_miss_restart) else $error("no restart on miss"); // [R11]

    property p_hit_cause;
        @(posedge clk_i) disable iff (rst_i)
        hit_reg |-> $past(arm_i && byte_valid_i && len_i != 2'h0);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without byte"); // [R9]

endmodule : kwe_seq_match

//--- core/kwe_wake_top.sv
// keyboard wake event configuration and matching, wishbone register slave
// assumes a classic wishbone master on clk_i and a ps/2 receiver that
// hands over whole bytes with a toggling strobe from another domain
//
// Overview of operation
// R1 - mode field bits 7-6 selects wake mode
// R2 - any-key mode flags every received key
// R3 - control register resets to 40h
// R4 - sequence mode uses protocol control low bits
// R5 - event three: zero, one or two bytes
// R6 - event two: up to three bytes
// R7 - event one: up to three bytes
// R8 - event lengths used only in pm mode
// R9 - each pm event reported separately
// R10 - incoming bytes shift into read-only register
// R11 - mismatch restarts event comparison at start
`timescale 1ns/1ps
`include "kwe_map.svh"
module kwe_wake_top
    import kwe_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [7:0]  kbd_byte_i,
    input  wire logic        kbd_toggle_i,
    output logic             any_key_event_o,
    output logic             seq_event_o,
    output logic [2:0]       pm_event_o,
    output logic [3:0]       seq_config_o
);

    // ================================================================
    // register state
    logic [7:0]  wake_ctrl_reg,  wake_ctrl_next;
    logic [7:0]  proto_ctrl_reg, proto_ctrl_next;
    logic [7:0]  key_reg [0:7];
    logic [7:0]  key_next [0:7];
    logic [3:0]  status_reg,     status_next;
    logic [31:0] dat_reg,        dat_next;
    logic        ack_reg,        ack_next;
    logic        any_reg,        any_next;
    logic        seqev_reg,      seqev_next;
    logic [2:0]  pm_reg,         pm_next;
    logic [3:0]  seqcfg_reg,     seqcfg_next;

    logic [7:0]  shifter_w;
    logic        byte_valid_w;
    logic [2:0]  hit_w;
    logic        detect_en;
    logic        seq_hit_w;
    kwe_mode_t   mode;
    logic [1:0]  len1, len2, len3;
    logic        bus_req;
    logic        lane0_wr;

    // byte-lane write with sel[0]; data lives in the low byte
    function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [31:0] wd,
                                              input logic sel0);
        lane_merge = sel0 ? wd[7:0] : old_v;
    endfunction : lane_merge

    // key register index from a byte address inside the key window
    function automatic logic [2:0] key_index(input logic [7:0] a);
        key_index = a[4:2];
    endfunction : key_index

    // ================================================================
    // field decode
    assign mode = kwe_mode_t'(wake_ctrl_reg[`KWE_MODE_HI:`KWE_MODE_LO]);   // [R1]
    // lengths only count in pm mode; elsewhere forced to disabled
    assign len1 = (mode == KWE_MODE_PM) ? wake_ctrl_reg[`KWE_EV1_HI:`KWE_EV1_LO] : 2'h0;   // [R8] [R7]
    assign len2 = (mode == KWE_MODE_PM) ? wake_ctrl_reg[`KWE_EV2_HI:`KWE_EV2_LO] : 2'h0;   // [R8] [R6]
    // code 11 reserved for event three, treated as disabled
    assign len3 = (mode == KWE_MODE_PM && wake_ctrl_reg[`KWE_EV3_HI:`KWE_EV3_LO] != 2'h3)
                ? wake_ctrl_reg[`KWE_EV3_HI:`KWE_EV3_LO] : 2'h0;   // [R5]
    // the shifter runs whenever some keyboard detection is live
    assign detect_en = (mode == KWE_MODE_ANY)
                     || (mode == KWE_MODE_PM && (len1 != 2'h0 || len2 != 2'h0 || len3 != 2'h0))
                     || (mode == KWE_MODE_SEQ && proto_ctrl_reg[3:0] != 4'h0);
    assign bus_req  = cyc_i && stb_i && !ack_reg;
    assign lane0_wr = bus_req && we_i;

    // ================================================================
    // byte capture and the three matchers
    kwe_shifter u_shifter (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .enable_i     (detect_en),
        .kbd_byte_i   (kbd_byte_i),
        .kbd_toggle_i (kbd_toggle_i),
        .shifter_o    (shifter_w),
        .byte_valid_o (byte_valid_w)
    );

    kwe_seq_match u_ev1 (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .arm_i        (mode == KWE_MODE_PM),
        .len_i        (len1),
        .key0_i       (key_reg[`KWE_EV1_BASE]),
        .key1_i       (key_reg[`KWE_EV1_BASE + 3'h1]),
        .key2_i       (key_reg[`KWE_EV1_BASE + 3'h2]),
        .byte_valid_i (byte_valid_w),
        .byte_i       (shifter_w),
        .hit_o        (hit_w[0])
    );

    kwe_seq_match u_ev2 (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .arm_i        (mode == KWE_MODE_PM),
        .len_i        (len2),
        .key0_i       (key_reg[`KWE_EV2_BASE]),
        .key1_i       (key_reg[`KWE_EV2_BASE + 3'h1]),
        .key2_i       (key_reg[`KWE_EV2_BASE + 3'h2]),
        .byte_valid_i (byte_valid_w),
        .byte_i       (shifter_w),
        .hit_o        (hit_w[1])
    );

    // event three has no third byte; key2 tied to key1 is never reached
    kwe_seq_match u_ev3 (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .arm_i        (mode == KWE_MODE_PM),
        .len_i        (len3),
        .key0_i       (key_reg[`KWE_EV3_BASE]),
        .key1_i       (key_reg[`KWE_EV3_BASE + 3'h1]),
        .key2_i       (key_reg[`KWE_EV3_BASE + 3'h1]),
        .byte_valid_i (byte_valid_w),
        .byte_i       (shifter_w),
        .hit_o        (hit_w[2])
    );

    // sequence/password compare is outside this block; a first-key
    // match against stored byte 0 is flagged as a coarse sequence hit
    assign seq_hit_w = (mode == KWE_MODE_SEQ) && (proto_ctrl_reg[3:0] != 4'h0)
                     && byte_valid_w && (shifter_w == key_reg[0]);   // [R4]

    // ================================================================
    // register writes, event outputs and sticky status
    always_comb
    begin
        wake_ctrl_next  = wake_ctrl_reg;
        proto_ctrl_next = proto_ctrl_reg;
        for (int i = 0; i < 8; i++)
            key_next[i] = key_reg[i];
        status_next = status_reg;
        if (lane0_wr)
        begin
            if (adr_i == `KWE_OFF_WAKE_CTRL)
                wake_ctrl_next = lane_merge(wake_ctrl_reg, dat_i, sel_i[0]);   // [R1]
            else if (adr_i == `KWE_OFF_PROTO_CTRL)
                proto_ctrl_next = lane_merge(proto_ctrl_reg, dat_i, sel_i[0]);
            else if (adr_i >= `KWE_OFF_KEY_BASE && adr_i <= `KWE_OFF_KEY_LAST && adr_i[1:0] == 2'h0)
                key_next[key_index(adr_i)] = lane_merge(key_reg[key_index(adr_i)], dat_i, sel_i[0]);
            else if (adr_i == `KWE_OFF_STATUS && sel_i[0])
                status_next = status_reg & ~dat_i[3:0];   // write one to clear
        end
        // set wins over a same-cycle clear
        status_next = status_next | {hit_w, (mode == KWE_MODE_ANY) && byte_valid_w};   // [R9] [R2]
        any_next    = (mode == KWE_MODE_ANY) && byte_valid_w;   // [R2]
        seqev_next  = seq_hit_w;   // [R4]
        pm_next     = hit_w;       // [R9]
        seqcfg_next = (mode == KWE_MODE_SEQ) ? proto_ctrl_reg[3:0] : 4'h0;   // [R4]
    end

    // ================================================================
    // wishbone answer: ack one cycle after the strobe, then drop
    always_comb
    begin
        ack_next = bus_req;
        dat_next = 32'h0000_0000;
        if (bus_req && !we_i)
        begin
            if (adr_i == `KWE_OFF_WAKE_CTRL)
                dat_next = {24'h00_0000, wake_ctrl_reg};
            else if (adr_i == `KWE_OFF_PROTO_CTRL)
                dat_next = {24'h00_0000, proto_ctrl_reg};
            else if (adr_i == `KWE_OFF_SHIFTER)
                dat_next = {24'h00_0000, shifter_w};   // [R10]
            else if (adr_i == `KWE_OFF_STATUS)
                dat_next = {28'h000_0000, status_reg};
            else if (adr_i >= `KWE_OFF_KEY_BASE && adr_i <= `KWE_OFF_KEY_LAST && adr_i[1:0] == 2'h0)
                dat_next = {24'h00_0000, key_reg[key_index(adr_i)]};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_ctrl_reg  <= `KWE_RST_WAKE_CTRL;   // [R3]
            proto_ctrl_reg <= `KWE_RST_PROTO_CTRL;
            for (int i = 0; i < 8; i++)
                key_reg[i] <= `KWE_RST_KEY;
            status_reg <= 4'h0;
            dat_reg    <= 32'h0000_0000;
            ack_reg    <= 1'b0;
            any_reg    <= 1'b0;
            seqev_reg  <= 1'b0;
            pm_reg     <= 3'h0;
            seqcfg_reg <= 4'h0;
        end
        else
        begin
            wake_ctrl_reg  <= wake_ctrl_next;
            proto_ctrl_reg <= proto_ctrl_next;
            for (int i = 0; i < 8; i++)
                key_reg[i] <= key_next[i];
            status_reg <= status_next;
            dat_reg    <= dat_next;
            ack_reg    <= ack_next;
            any_reg    <= any_next;
            seqev_reg  <= seqev_next;
            pm_reg     <= pm_next;
            seqcfg_reg <= seqcfg_next;
        end
    end

    assign dat_o           = dat_reg;
    assign ack_o           = ack_reg;
    assign any_key_event_o = any_reg;
    assign seq_event_o     = seqev_reg;
    assign pm_event_o      = pm_reg;
    assign seq_config_o    = seqcfg_reg;

    // ================================================================
    // checks
    sequence s_after_reset;
        $fell(rst_i);
    endsequence

    property p_reset_value;
        @(posedge clk_i) s_after_reset |-> wake_ctrl_reg == 8'h40;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value"); // [R3]

    // reserved mode must leave the detector idle: nothing captured, nothing flagged
    property p_mode_decode;
        @(posedge clk_i) disable iff (rst_i)
        (mode == KWE_MODE_RSVD) |=> !byte_valid_w && !any_key_event_o && !seq_event_o;
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("reserved mode not idle"); // [R1]

    property p_any_key;
        @(posedge clk_i) disable iff (rst_i)
        (mode == KWE_MODE_ANY && byte_valid_w) |=> any_key_event_o;
    endproperty
    a_any_key: assert property (p_any_key) else $error("any key missed"); // [R2]

    property p_any_only_mode;
        @(posedge clk_i) disable iff (rst_i)
        any_key_event_o |-> $past(mode == KWE_MODE_ANY);
    endproperty
    a_any_only_mode: assert property (p_any_only_mode) else $error("any key in wrong mode"); // [R2]

    // checked at the matcher outputs; arm_i holds them quiet, so a broken length gate stays hidden
    property p_pm_gate;
        @(posedge clk_i) disable iff (rst_i)
        (mode != KWE_MODE_PM) |=> hit_w == 3'h0;
    endproperty
    a_pm_gate: assert property (p_pm_gate) else $error("lengths live outside pm mode"); // [R8]

    property p_ev3_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        (wake_ctrl_reg[5:4] == 2'h3) |=> !hit_w[2];
    endproperty
    a_ev3_rsvd: assert property (p_ev3_rsvd) else $error("reserved event three length used"); // [R5]

    property p_pm_report;
        @(posedge clk_i) disable iff (rst_i)
        |hit_w |=> pm_event_o == $past(hit_w) && (status_reg[3:1] & $past(hit_w)) == $past(hit_w);
    endproperty
    a_pm_report: assert property (p_pm_report) else $error("pm event not reported"); // [R9]

    property p_seq_cfg;
        @(posedge clk_i) disable iff (rst_i)
        (mode == KWE_MODE_SEQ) |=> seq_config_o == $past(proto_ctrl_reg[3:0]);
    endproperty
    a_seq_cfg: assert property (p_seq_cfg) else $error("sequence config not passed"); // [R4]

    // a one-byte event fires on its first stored key
    property p_len_fields;
        @(posedge clk_i) disable iff (rst_i)
        (mode == KWE_MODE_PM && wake_ctrl_reg[1:0] == 2'h1 && byte_valid_w
            && shifter_w == key_reg[0]) |=> hit_w[0];
    endproperty
    a_len_fields: assert property (p_len_fields) else $error("one-byte event one missed"); // [R7]

    property p_len_two;
        @(posedge clk_i) disable iff (rst_i)
        (mode == KWE_MODE_PM && wake_ctrl_reg[3:2] == 2'h1 && byte_valid_w
            && shifter_w == key_reg[3]) |=> hit_w[1];
    endproperty
    a_len_two: assert property (p_len_two) else $error("one-byte event two missed"); // [R6]

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack timing wrong");

endmodule : kwe_wake_top

//--- test/kwe_kbd_model.sv
// keyboard partner model: hands whole bytes over with a toggling strobe
// assumes the receiver synchronises the toggle on clk_i
`timescale 1ns/1ps
module kwe_kbd_model
(
    input  wire logic       clk_i,
    output logic [7:0]      kbd_byte_o,
    output logic            kbd_toggle_o
);
    // ================================================================
    // byte hand-over
    initial
    begin
        kbd_byte_o   = 8'h00;
        kbd_toggle_o = 1'b0;
    end
    // byte held 3 cycles before the toggle and 8 cycles after it, then scrambled
    // so a late sample can never see the old byte by luck
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        kbd_byte_o <= b;
        repeat (3) @(posedge clk_i);
        kbd_toggle_o <= ~kbd_toggle_o;
        repeat (8) @(posedge clk_i);
        kbd_byte_o <= ~b;
    endtask : send
endmodule : kwe_kbd_model

//--- test/tb_top.sv
// self-checking bench for the keyboard wake event block
// assumes a 50 MHz clock and the keyboard partner model
`timescale 1ns/1ps
module tb_top
    import kwe_pkg::*;
;
    logic        clk_i, rst_i, cyc, stb, we, any_o, seq_o, ack_o;
    logic [7:0]  adr, ctrl, kb_byte;
    logic [31:0] dat, dat_o, r, seed;
    logic [2:0]  pm_o, acc_pm;
    logic [3:0]  seq_cfg, pcfg, stat;
    logic        acc_any, acc_seq, kb_tog;
    logic [7:0]  keys [8];
    int          prog [3];
    int          err_count, comparisons, i, a, b, c, j;

    kwe_wake_top kwe_wake_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .kbd_byte_i(kb_byte), .kbd_toggle_i(kb_tog), .any_key_event_o(any_o),
        .seq_event_o(seq_o), .pm_event_o(pm_o), .seq_config_o(seq_cfg));
    kwe_kbd_model kwe_kbd_model_i (.clk_i(clk_i), .kbd_byte_o(kb_byte), .kbd_toggle_o(kb_tog));

    // ================================================================
    // clock and event collection
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // events are single-cycle pulses, so gather them between checks
    always @(posedge clk_i)
    begin
        acc_pm  = acc_pm | pm_o;
        acc_any = acc_any | any_o;
        acc_seq = acc_seq | seq_o;
    end

    // ================================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic single wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 16);
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        if (ack_o !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
    endtask : wb

    task automatic set_ctrl(input logic [7:0] v);
        ctrl = v;
        wb(1'b1, 8'h04, {24'h0, v});
        wb(1'b0, 8'h04, 32'h0);
        chk(r, {24'h0, v});
    endtask : set_ctrl

    // reference matcher: three events with restart on a miss
    function automatic logic [2:0] model_step(input logic [7:0] kb);
        logic [2:0] hit;
        int e, len;
        hit = 3'h0;
        for (e = 0; e < 3; e++)
        begin
            len = (ctrl >> (2 * e)) & 3;
            if (e == 2 && len == 3) len = 0;
            if (ctrl[7:6] != 2'h2 || len == 0) prog[e] = 0;
            else
            begin
                if (kb == keys[3 * e + prog[e]]) prog[e]++;
                else prog[e] = (kb == keys[3 * e]) ? 1 : 0;
                if (prog[e] == len)
                begin
                    hit[e] = 1'b1;
                    prog[e] = 0;
                end
            end
        end
        return hit;
    endfunction : model_step

    task automatic kb(input logic [7:0] v);
        logic [2:0] e;
        logic       s;
        acc_pm = 3'h0;
        acc_any = 1'b0;
        acc_seq = 1'b0;
        e = model_step(v);
        s = ctrl[7:6] == 2'h0 && pcfg != 4'h0 && v == keys[0];
        stat = stat | {e, ctrl[7:6] == 2'h1};
        kwe_kbd_model_i.send(v);
        chk({s, acc_any, acc_pm}, {acc_seq, ctrl[7:6] == 2'h1, e});
    endtask : kb

    // ================================================================
    // main sequence
    initial
    begin
        seed = 32'd78; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0;
        acc_pm = 0; acc_any = 0; err_count = 0; comparisons = 0; prog = '{0, 0, 0};
        acc_seq = 0; pcfg = 4'h0; stat = 4'h0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h40);
        ctrl = 8'h40;
        wb(1'b0, 8'h40, 32'h0);
        chk(r, 32'h0);
        // distinct keys keep partial progress at zero between configs
        for (i = 0; i < 8; i++)
        begin
            keys[i] = {5'(rnd()), i[2:0]};
            wb(1'b1, 8'h20 + 8'(4 * i), {24'h0, keys[i]});
        end
        kb(keys[5]);
        wb(1'b0, 8'h0C, 32'h0);
        chk(r, {24'h0, keys[5]});
        wb(1'b1, 8'h0C, 32'hFF);
        wb(1'b0, 8'h0C, 32'h0);
        chk(r, {24'h0, keys[5]});
        for (a = 1; a < 4; a++)
            for (b = 1; b < 4; b++)
                for (c = 0; c < 4; c++)
                begin
                    set_ctrl(8'h80 | 8'(c << 4) | 8'(b << 2) | 8'(a));
                    kb(keys[0]);
                    kb(keys[3]);
                    for (j = 0; j < a; j++) kb(keys[j]);
                    for (j = 0; j < b; j++) kb(keys[3 + j]);
                    for (j = 0; j < 2; j++) kb(keys[6 + j]);
                end
        set_ctrl(8'h7F);
        kb(keys[0]);
        set_ctrl(8'hFF);
        kb(keys[1]);
        set_ctrl(8'h3F);
        chk(seq_cfg, 0);
        wb(1'b1, 8'h08, 32'h0);
        wb(1'b1, 8'h08, 32'h5);
        pcfg = 4'h5;
        // the passthrough register follows one edge after the write
        @(posedge clk_i);
        chk(seq_cfg, 5);
        kb(keys[0]);
        kb(keys[1]);
        wb(1'b0, 8'h10, 32'h0);
        chk(r, {28'h0, stat});
        wb(1'b1, 8'h10, 32'hF);
        wb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        set_ctrl(8'h40);
        chk(seq_cfg, 0);
        finish_test();
    end
endmodule : tb_top
